// File: verification/host_pin_model.sv
`timescale 1ns/10ps
`default_nettype none
module host_pin_model (
    // Device pin drivers.
    input  wire logic selOut,
    input  wire logic selOe,
    input  wire logic rxdOut,
    input  wire logic rxdOe,
    input  wire logic txcOut,
    input  wire logic txcOe,
    // Host intent.
    input  wire logic strapLow,
    input  wire logic hostTwoWire,
    input  wire logic hostTx,
    input  wire logic hostSda_n,
    input  wire logic hostScl_n,
    // Resolved pin levels.
    output logic      selIn,
    output logic      rxdIn,
    output logic      txcIn
);
    assign selIn = selOe ? selOut : !strapLow;
    assign rxdIn = hostTwoWire ? !((rxdOe && !rxdOut) || !hostSda_n) : hostTx;
    assign txcIn = hostTwoWire ? !((txcOe && !txcOut) || !hostScl_n) : (txcOe ? txcOut : 1'b1);
endmodule : host_pin_model
`default_nettype wire

// File: verification/interface_select_sleep_control_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module interface_select_sleep_control_tb_top;
    localparam int SC = 20;
    localparam int ST = 50;
    logic clock = 0, srst = 1, resetPin_n = 1, sleepPin_n = 1, uartTx = 1;
    logic sdaDrive_n = 1, sclDrive_n = 1, pulseActive = 0, strapLow = 0;
    logic hostTwoWire = 0, hostTx = 1, hostSda_n = 1, hostScl_n = 1;
    logic selIn, rxdIn, txcIn, selOut, selOe, rxdOut, rxdOe, txcOut, txcOe, uartRx;
    logic sdaLevel, sclLevel, twoWireMode, selDone, fanOn, dataValid;
    int   bad_count = 0;
    int   tests_run = 0;
    int   cyc = 0;
    int   n;

    always #2 clock = ~clock;

    interface_select_sleep_control #(.SAMPLE_CYCLES(SC), .SETTLE_CYCLES(ST)) u_dut (
        .clock, .srst, .resetPin_n, .sleepPin_n, .selIn, .selOut, .selOe, .rxdIn, .rxdOut,
        .rxdOe, .txcIn, .txcOut, .txcOe, .uartTx, .uartRx, .sdaDrive_n, .sclDrive_n,
        .sdaLevel, .sclLevel, .pulseActive, .twoWireMode, .selDone, .fanOn, .dataValid);

    host_pin_model u_host (
        .selOut, .selOe, .rxdOut, .rxdOe, .txcOut, .txcOe, .strapLow, .hostTwoWire,
        .hostTx, .hostSda_n, .hostScl_n, .selIn, .rxdIn, .txcIn);

    function automatic logic rb();
        return 1'($urandom());
    endfunction : rb

    // An open-drain line is high unless some party pulls it low.
    function automatic logic wired(input logic a, input logic b);
        return a & b;
    endfunction : wired

    task automatic check(input logic seen, input logic exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %0t: seen %b expected %b", $time, seen, exp);
        end
    endtask : check

    task automatic tick(input int k);
        repeat (k) @(posedge clock);
        #1;
    endtask : tick

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : test_done

    task automatic wait_valid();
        n = 0;
        while (dataValid !== 1'b1 && n < ST + 10) begin
            tick(1);
            n++;
        end
    endtask : wait_valid

    // Resets through srst or the reset pin, then checks the latched choice.
    task automatic boot(input logic s, input logic usePin);
        strapLow = s;
        hostTwoWire = s;
        if (usePin) resetPin_n = 0;
        else srst = 1;
        tick(3);
        check(selDone, 1'b0);
        resetPin_n = 1;
        srst = 0;
        n = 0;
        while (selDone !== 1'b1 && n < SC + 10) begin
            tick(1);
            n++;
        end
        check(n >= SC && n <= SC + 4, 1'b1);
        tick(2);
        check(twoWireMode, s);
        check(selOe, !s);
        strapLow = !s;
        tick(5);
        check(twoWireMode, s);
    endtask : boot

    always @(posedge clock) begin
        cyc++;
        if (cyc == 3000) begin
            bad_count++;
            test_done();
        end
    end

    initial begin
        void'($urandom(32'h3FBE));
        boot(1'b0, 1'b0);
        repeat (6) begin
            pulseActive = rb();
            uartTx = rb();
            hostTx = rb();
            sdaDrive_n = rb();
            sclDrive_n = rb();
            tick(4);
            check(selOut, !pulseActive);
            check(txcOut, uartTx);
            check(txcOe, 1'b1);
            check(uartRx, hostTx);
            check(rxdOe, 1'b0);
            check(sdaLevel, 1'b1);
            check(sclLevel, 1'b1);
        end
        check(dataValid, 1'b0);
        wait_valid();
        check(dataValid, 1'b1);
        sleepPin_n = 0;
        tick(5);
        check(fanOn, 1'b0);
        check(dataValid, 1'b0);
        tick(20);
        sleepPin_n = 1;
        wait_valid();
        check(n >= ST && n <= ST + 6, 1'b1);
        check(fanOn, 1'b1);
        boot(1'b1, 1'b1);
        repeat (8) begin
            sdaDrive_n = rb();
            sclDrive_n = rb();
            hostSda_n = rb();
            hostScl_n = rb();
            uartTx = rb();
            pulseActive = rb();
            tick(4);
            check(rxdOe, !sdaDrive_n);
            check(rxdOut, 1'b0);
            check(txcOe, !sclDrive_n);
            check(sdaLevel, wired(sdaDrive_n, hostSda_n));
            check(sclLevel, wired(sclDrive_n, hostScl_n));
            check(uartRx, 1'b1);
            check(selOe, 1'b0);
            check(txcOut, 1'b0);
        end
        // Sleep while still settling after the second boot.
        check(dataValid, 1'b0);
        sleepPin_n = 0;
        tick(5);
        check(fanOn, 1'b0);
        check(dataValid, 1'b0);
        sleepPin_n = 1;
        wait_valid();
        check(n >= ST && n <= ST + 6, 1'b1);
        check(dataValid, 1'b1);
        test_done();
    end
endmodule : interface_select_sleep_control_tb_top
`default_nettype wire

// File: verilog/iface_sel_consts.svh
`ifndef IFACE_SEL_CONSTS_SVH
`define IFACE_SEL_CONSTS_SVH
// Clock rate in kHz and derived cycle counts.
// Sized to 64 bits so that the settling count does not overflow 32-bit arithmetic.
`define CLK_KHZ          64'h3D090
`define SAMPLE_WINDOW_MS 64'h3E8
`define SETTLE_MS        64'h7530
`define SAMPLE_CYCLES    (`CLK_KHZ * `SAMPLE_WINDOW_MS)
`define SETTLE_CYCLES    (`CLK_KHZ * `SETTLE_MS)
`define SYNC_STAGES      2
`endif

// File: verilog/iface_sel_pkg.sv
package iface_sel_pkg;
    typedef enum logic {
        IF_ASYNC,
        IF_TWOWIRE
    } iface_t;
    typedef enum logic [1:0] {
        ST_SAMPLING,
        ST_SETTLING,
        ST_RUNNING,
        ST_DORMANT
    } phase_t;
endpackage : iface_sel_pkg

// File: verilog/interface_select_sleep_control.sv
// Behaviour
// - Within one second of power-on the select pin level is sampled to pick the interface.
// - A high or floating select level makes the select pin a pulse output and enables async serial.
// - A low select level disables the pulse output and enables the two-wire interface.
// - The pulse output is active low, the measured value lying in its low portion.
// - A high or floating sleep input means normal operation, a low one means dormancy.
// - Dormancy stops the fan and waking requires a 30 second settling time before valid data.
// - The transmit/clock pin is serial transmit in async mode and bus clock in two-wire mode.
// - The receive/data pin is serial receive in async mode and bidirectional bus data in two-wire.
// - A low reset input resets the device, a high or floating one lets it run.
`timescale 1ns/10ps
`default_nettype none
`include "iface_sel_consts.svh"
module interface_select_sleep_control #(
    parameter longint unsigned SAMPLE_CYCLES = `SAMPLE_CYCLES,
    parameter longint unsigned SETTLE_CYCLES = `SETTLE_CYCLES
) (
    // Clock and power-on reset.
    input  wire logic clock,
    input  wire logic srst,
    // Control pins from the host.
    input  wire logic resetPin_n,
    input  wire logic sleepPin_n,
    // Select / pulse-width pin.
    input  wire logic selIn,
    output logic      selOut,
    output logic      selOe,
    // Receive/data pin.
    input  wire logic rxdIn,
    output logic      rxdOut,
    output logic      rxdOe,
    // Transmit/clock pin.
    input  wire logic txcIn,
    output logic      txcOut,
    output logic      txcOe,
    // Internal async serial side.
    input  wire logic uartTx,
    output logic      uartRx,
    // Internal two-wire side.
    input  wire logic sdaDrive_n,
    input  wire logic sclDrive_n,
    output logic      sdaLevel,
    output logic      sclLevel,
    // Internal pulse generator, high means the active part.
    input  wire logic pulseActive,
    // Status toward the core.
    output logic      twoWireMode,
    output logic      selDone,
    output logic      fanOn,
    output logic      dataValid
);
    localparam int CW = 34;

    logic [4:0]                 syncd;
    logic                       txcLvl;
    logic                       rstLvl;
    logic                       sleepLvl;
    logic                       selLvl;
    logic                       rxdLvl;
    logic                       coreRst;
    logic [CW-1:0]              count;
    iface_sel_pkg::iface_t      iface;
    iface_sel_pkg::phase_t      phase;

    if (SAMPLE_CYCLES < 1 || SETTLE_CYCLES < 1) begin : g_bad_count
        $error("counts must be at least one cycle");
    end

    // The shared counter must reach both terminal counts.
    if (SAMPLE_CYCLES > (64'h1 << CW) || SETTLE_CYCLES > (64'h1 << CW)) begin : g_bad_range
        $error("counts do not fit the cycle counter");
    end

    // The clock line is a pin too, so it is synchronised like the others.
    pin_sync #(
        .WIDTH(5)
    ) u_sync (
        .clock (clock),
        .srst  (srst),
        .pinIn ({resetPin_n, sleepPin_n, selIn, rxdIn, txcIn}),
        .pinOut(syncd)
    );

    assign rstLvl   = syncd[4];
    assign sleepLvl = syncd[3];
    assign selLvl   = syncd[2];
    assign rxdLvl   = syncd[1];
    assign txcLvl   = syncd[0];

    assign coreRst = srst || !rstLvl;

    // Phase sequencing with one shared cycle counter.
    always_ff @(posedge clock) begin
        if (coreRst) begin
            phase <= iface_sel_pkg::ST_SAMPLING;
            count <= '0;
        end else begin
            unique case (phase)
                iface_sel_pkg::ST_SAMPLING: begin
                    if (count >= CW'(SAMPLE_CYCLES - 1)) begin
                        phase <= iface_sel_pkg::ST_SETTLING;
                        count <= '0;
                    end else begin
                        count <= count + 1'b1;
                    end
                end
                iface_sel_pkg::ST_SETTLING: begin
                    if (!sleepLvl) begin
                        phase <= iface_sel_pkg::ST_DORMANT;
                        count <= '0;
                    end else if (count >= CW'(SETTLE_CYCLES - 1)) begin
                        phase <= iface_sel_pkg::ST_RUNNING;
                    end else begin
                        count <= count + 1'b1;
                    end
                end
                iface_sel_pkg::ST_RUNNING: begin
                    if (!sleepLvl) begin
                        phase <= iface_sel_pkg::ST_DORMANT;
                    end
                end
                iface_sel_pkg::ST_DORMANT: begin
                    count <= '0;
                    if (sleepLvl) begin
                        phase <= iface_sel_pkg::ST_SETTLING;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (coreRst) begin
            iface   <= iface_sel_pkg::IF_ASYNC;
            selDone <= 1'b0;
        end else if (phase == iface_sel_pkg::ST_SAMPLING
                     && count >= CW'(SAMPLE_CYCLES - 1)) begin
            iface   <= selLvl ? iface_sel_pkg::IF_ASYNC : iface_sel_pkg::IF_TWOWIRE;
            selDone <= 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (coreRst) begin
            fanOn     <= 1'b1;
            dataValid <= 1'b0;
        end else begin
            fanOn     <= phase != iface_sel_pkg::ST_DORMANT;
            dataValid <= phase == iface_sel_pkg::ST_RUNNING;
        end
    end

    // Pin steering; select pin is input until the choice is made.
    always_ff @(posedge clock) begin
        if (coreRst) begin
            twoWireMode <= 1'b0;
            selOut      <= 1'b1;
            selOe       <= 1'b0;
            rxdOut      <= 1'b0;
            rxdOe       <= 1'b0;
            txcOut      <= 1'b1;
            txcOe       <= 1'b0;
            uartRx      <= 1'b1;
            sdaLevel    <= 1'b1;
            sclLevel    <= 1'b1;
        end else if (iface == iface_sel_pkg::IF_TWOWIRE) begin
            twoWireMode <= 1'b1;
            selOut      <= 1'b1;
            selOe       <= 1'b0;
            rxdOut      <= 1'b0;
            rxdOe       <= !sdaDrive_n;
            sdaLevel    <= rxdLvl;
            txcOut      <= 1'b0;
            txcOe       <= !sclDrive_n;
            sclLevel    <= txcLvl;
            uartRx      <= 1'b1;
        end else begin
            twoWireMode <= 1'b0;
            selOut      <= !pulseActive;
            selOe       <= selDone;
            rxdOut      <= 1'b0;
            rxdOe       <= 1'b0;
            uartRx      <= rxdLvl;
            txcOut      <= uartTx;
            txcOe       <= selDone;
            sdaLevel    <= 1'b1;
            sclLevel    <= 1'b1;
        end
    end

    sequence s_wake;
        phase == iface_sel_pkg::ST_DORMANT ##1 phase == iface_sel_pkg::ST_SETTLING;
    endsequence

    a_valid_after_settle: assert property (@(posedge clock) disable iff (coreRst)
        s_wake |-> !dataValid[*8])
        else $error("data valid too soon after waking");

    a_dormant_fan_off: assert property (@(posedge clock) disable iff (coreRst)
        phase == iface_sel_pkg::ST_DORMANT |=> !fanOn)
        else $error("fan running while dormant");

    a_sleep_enters: assert property (@(posedge clock) disable iff (coreRst)
        (phase == iface_sel_pkg::ST_RUNNING && !sleepLvl) |=>
            phase == iface_sel_pkg::ST_DORMANT)
        else $error("sleep level ignored");

    a_sel_held: assert property (@(posedge clock) disable iff (coreRst)
        selDone |=> selDone && $stable(iface))
        else $error("selection changed after latch");

    a_sel_low_twowire: assert property (@(posedge clock) disable iff (coreRst)
        (phase == iface_sel_pkg::ST_SAMPLING && count >= CW'(SAMPLE_CYCLES - 1) && !selLvl)
            |=> ##1 twoWireMode && !selOe)
        else $error("low select did not pick two-wire");

    a_sel_high_async: assert property (@(posedge clock) disable iff (coreRst)
        (phase == iface_sel_pkg::ST_SAMPLING && count >= CW'(SAMPLE_CYCLES - 1) && selLvl)
            |=> ##1 !twoWireMode && selOe && txcOe)
        else $error("high select did not pick async");

    a_pulse_low: assert property (@(posedge clock) disable iff (coreRst)
        (iface == iface_sel_pkg::IF_ASYNC && selDone && pulseActive) |=> !selOut)
        else $error("pulse active not driven low");

    a_tx_forward: assert property (@(posedge clock) disable iff (coreRst)
        (iface == iface_sel_pkg::IF_ASYNC && selDone) |=> txcOut == $past(uartTx))
        else $error("transmit not forwarded");

    a_sda_release: assert property (@(posedge clock) disable iff (coreRst)
        (iface == iface_sel_pkg::IF_TWOWIRE && sdaDrive_n) |=> !rxdOe)
        else $error("data line driven when released");

    a_reset_pin: assert property (@(posedge clock) disable iff (srst)
        !rstLvl |=> phase == iface_sel_pkg::ST_SAMPLING && !selDone)
        else $error("reset pin ignored");

    a_sample_once: assert property (@(posedge clock) disable iff (coreRst)
        (phase == iface_sel_pkg::ST_SAMPLING && count >= CW'(SAMPLE_CYCLES - 1))
            |=> selDone && phase == iface_sel_pkg::ST_SETTLING)
        else $error("sampling window did not close");
endmodule : interface_select_sleep_control
`default_nettype wire

// File: verilog/pin_sync.sv
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
    parameter int WIDTH = 4
) (
    // Clock and reset.
    input  wire logic             clock,
    input  wire logic             srst,
    // Pins in and synchronised levels out.
    input  wire logic [WIDTH-1:0] pinIn,
    output logic      [WIDTH-1:0] pinOut
);
    logic [WIDTH-1:0] stage1;

    if (WIDTH < 1) begin : g_bad_width
        $error("pin_sync: WIDTH must be at least 1");
    end

    // Reset to high, the level of a pulled-up floating pin.
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            always_ff @(posedge clock) begin
                if (srst) begin
                    stage1[i] <= 1'b1;
                    pinOut[i] <= 1'b1;
                end else begin
                    stage1[i] <= pinIn[i];
                    pinOut[i] <= stage1[i];
                end
            end
        end
    endgenerate
endmodule : pin_sync
`default_nettype wire
